// File: rtl/gmbsc_device.sv
// Module end: chip reset/mode control, serial transmitter, time pulse,
// antenna supervision and power-state tracking.
// Assumes pin and sensor inputs are asynchronous; user-side inputs are local.
`timescale 1ns/10ps
`default_nettype none
module gmbsc_device #(
    parameter int PPS_PERIOD_CYC = gmbsc_pkg::PPS_PERIOD_CYC,
    parameter int PPS_HIGH_CYC   = gmbsc_pkg::PPS_HIGH_CYC
) (
    input  wire logic        ref_clk_in,
    input  wire logic        arst_n_in,
    gmbsc_if.dev             link,
    input  wire logic        main_pwr_in,
    input  wire logic        backup_supply_in,
    input  wire logic        aid_data_in,
    input  wire logic [1:0]  dl_done_in,
    input  wire logic [7:0]  tx_data_in,
    input  wire logic        tx_valid_in,
    input  wire logic [1:0]  ant_overcur_in,
    input  wire logic [1:0]  ant_undercur_in,
    input  wire logic        cfg_we_in,
    input  wire logic [3:0]  cfg_msg_in,
    output logic             tx_ready_out,
    output logic [3:0]       chip_state_out,
    output logic [3:0]       msg_en_out,
    output logic [3:0]       ant_state_out,
    output logic [1:0]       ant_bias_en_out,
    output logic [15:0]      ant_cksum_out,
    output logic             standby_out,
    output logic             start_cold_out
);
    localparam int PCW = $clog2(PPS_PERIOD_CYC + 1);
    localparam int BCW = $clog2(gmbsc_pkg::BAUD_CYC + 1);

    logic [9:0] raw;
    logic [9:0] s1_q;
    logic [9:0] s2_q;
    logic       rst_n;
    logic [1:0] sel;
    logic       rx;
    logic       mpwr;
    logic       bak;
    logic [1:0] oc;
    logic [1:0] uc;

    // Pins and sensor levels pass two flops before use
    assign raw = {ant_undercur_in, ant_overcur_in, backup_supply_in, main_pwr_in,
                  link.rx_lvl, link.sels_lvl, link.selm_lvl, link.rst_lvl};
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s1_q <= 10'h007;
            s2_q <= 10'h007;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end
    assign rst_n = s2_q[0];
    assign sel   = s2_q[2:1];
    assign rx    = s2_q[3];
    assign mpwr  = s2_q[4];
    assign bak   = s2_q[5];
    assign oc    = s2_q[7:6];
    assign uc    = s2_q[9:8];

    gmbsc_pkg::gmbsc_chip_t st_q [2];
    gmbsc_pkg::gmbsc_chip_t st_d [2];

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            st_d[i] = st_q[i];
            if (!rst_n || !mpwr) begin
                st_d[i] = gmbsc_pkg::CH_RESET; // [RQ1] [RQ2]
            end else begin
                case (st_q[i])
                    gmbsc_pkg::CH_RESET: begin
                        // Each chip reads its own select at release [RQ3] [RQ4]
                        st_d[i] = (sel[i] == gmbsc_pkg::SEL_BOOT) ?
                                  gmbsc_pkg::CH_BOOT : gmbsc_pkg::CH_USER;
                    end
                    gmbsc_pkg::CH_USER: begin
                        if (dl_done_in[i]) begin
                            st_d[i] = gmbsc_pkg::CH_RESET; // [RQ6]
                        end
                    end
                    gmbsc_pkg::CH_BOOT: begin
                        st_d[i] = gmbsc_pkg::CH_BOOT; // [RQ7]
                    end
                    default: begin
                        st_d[i] = gmbsc_pkg::CH_RESET;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q[0] <= gmbsc_pkg::CH_RESET;
            st_q[1] <= gmbsc_pkg::CH_RESET;
        end else begin
            st_q[0] <= st_d[0];
            st_q[1] <= st_d[1];
        end
    end
    assign chip_state_out = {st_q[1], st_q[0]};

    // Sentence enables; power loss restores the defaults
    logic [3:0] msg_q;
    logic [3:0] msg_d;
    always_comb begin
        msg_d = msg_q;
        if (!mpwr) begin
            msg_d = gmbsc_pkg::MSG_DEFAULT; // [RQ11]
        end else if (cfg_we_in) begin
            msg_d = cfg_msg_in;
        end
    end
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            msg_q <= gmbsc_pkg::MSG_DEFAULT; // [RQ11]
        end else begin
            msg_q <= msg_d;
        end
    end
    assign msg_en_out = msg_q;

    // Serial transmitter, master chip in user mode only
    logic [9:0]     frm_q;
    logic [9:0]     frm_d;
    logic [3:0]     bit_q;
    logic [3:0]     bit_d;
    logic [BCW-1:0] bd_q;
    logic [BCW-1:0] bd_d;
    logic           txl_q;
    logic           txl_d;
    logic           rdy_q;
    logic           rdy_d;
    always_comb begin
        frm_d = frm_q;
        bit_d = bit_q;
        bd_d  = bd_q;
        txl_d = txl_q;
        if (st_q[0] != gmbsc_pkg::CH_USER) begin
            bit_d = 4'h0;
            txl_d = 1'b1;
        end else if (bit_q == 4'h0) begin
            if (tx_valid_in && rdy_q) begin
                frm_d = {1'b1, tx_data_in, 1'b0}; // [RQ9]
                bit_d = 4'(gmbsc_pkg::FRAME_BITS);
                bd_d  = BCW'(gmbsc_pkg::BAUD_CYC - 1);
                txl_d = 1'b0;
            end
        end else if (bd_q != '0) begin
            bd_d = bd_q - 1'b1;
        end else begin
            bd_d  = BCW'(gmbsc_pkg::BAUD_CYC - 1); // [RQ10]
            frm_d = {1'b1, frm_q[9:1]};
            bit_d = bit_q - 4'h1;
            txl_d = (bit_q == 4'h1) ? 1'b1 : frm_q[1];
        end
        // Ready drops the cycle a byte is taken, so no byte is taken twice
        rdy_d = (st_d[0] == gmbsc_pkg::CH_USER) && (bit_d == 4'h0);
    end
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            frm_q <= 10'h3ff;
            bit_q <= 4'h0;
            bd_q  <= '0;
            txl_q <= 1'b1;
            rdy_q <= 1'b0;
        end else begin
            frm_q <= frm_d;
            bit_q <= bit_d;
            bd_q  <= bd_d;
            txl_q <= txl_d;
            rdy_q <= rdy_d;
        end
    end
    assign link.dev_tx  = txl_q;
    assign tx_ready_out = rdy_q;

    // Time pulse restarts its second when the master leaves reset
    logic [PCW-1:0] pc_q;
    logic [PCW-1:0] pc_d;
    logic           pps_q;
    logic           pps_d;
    // Parked at end of count so the first pulse is full length
    always_comb begin
        pc_d  = PCW'(PPS_PERIOD_CYC - 1);
        pps_d = 1'b0;
        if (st_q[0] != gmbsc_pkg::CH_RESET) begin
            pc_d  = (pc_q == PCW'(PPS_PERIOD_CYC - 1)) ? '0 : pc_q + 1'b1;
            pps_d = (pc_d < PCW'(PPS_HIGH_CYC)); // [RQ12]
        end
    end
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pc_q  <= PCW'(PPS_PERIOD_CYC - 1);
            pps_q <= 1'b0;
        end else begin
            pc_q  <= pc_d;
            pps_q <= pps_d;
        end
    end
    assign link.pps = pps_q;

    // Antenna supervision; short wins over open
    gmbsc_pkg::gmbsc_ant_t ant_d [2];
    logic [3:0]  ast_q;
    logic [1:0]  bias_q;
    logic [1:0]  bias_d;
    logic [15:0] cks_q;
    logic [15:0] cks_d;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            ant_d[i] = oc[i] ? gmbsc_pkg::ANT_SHORT :
                       uc[i] ? gmbsc_pkg::ANT_OPEN : gmbsc_pkg::ANT_OK; // [RQ13]
            bias_d[i] = !oc[i]; // [RQ13]
            case (ant_d[i])
                gmbsc_pkg::ANT_SHORT: cks_d[8*i +: 8] = gmbsc_pkg::CKS_SHORT; // [RQ14]
                gmbsc_pkg::ANT_OPEN:  cks_d[8*i +: 8] = gmbsc_pkg::CKS_OPEN;  // [RQ14]
                default:              cks_d[8*i +: 8] = gmbsc_pkg::CKS_OK;    // [RQ14]
            endcase
        end
    end
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ast_q  <= 4'h0;
            bias_q <= 2'h0;
            cks_q  <= {gmbsc_pkg::CKS_OK, gmbsc_pkg::CKS_OK};
        end else begin
            ast_q  <= {ant_d[1], ant_d[0]};
            bias_q <= bias_d;
            cks_q  <= cks_d;
        end
    end
    assign ant_state_out   = ast_q;
    assign ant_bias_en_out = bias_q;
    assign ant_cksum_out   = cks_q;

    // Power state; first power-on counts as cold unless aid data is present
    logic kept_q;
    logic kept_d;
    logic mp_q;
    logic sb_q;
    logic sb_d;
    logic cold_q;
    logic cold_d;
    always_comb begin
        kept_d = mpwr ? 1'b1 : (kept_q & bak);
        // A driven-high serial line keeps the module awake [RQ17]
        sb_d   = !mpwr && bak && !rx; // [RQ15]
        cold_d = cold_q;
        if (mpwr && !mp_q) begin
            cold_d = !kept_q && !aid_data_in; // [RQ15] [RQ16]
        end
    end
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            kept_q <= 1'b0;
            mp_q   <= 1'b0;
            sb_q   <= 1'b0;
            cold_q <= 1'b1;
        end else begin
            kept_q <= kept_d;
            mp_q   <= mpwr;
            sb_q   <= sb_d;
            cold_q <= cold_d;
        end
    end
    assign standby_out    = sb_q;
    assign start_cold_out = cold_q;
endmodule
`default_nettype wire

// File: rtl/gmbsc_host.sv
// Host end: open-drain reset/mode sequencing and serial line drive.
// Assumes module outputs arrive asynchronously on pins.
`timescale 1ns/10ps
`default_nettype none
module gmbsc_host #(
    parameter int RST_HOLD_CYC = gmbsc_pkg::RST_MIN_CYC,
    parameter int SEL_HOLD_CYC = gmbsc_pkg::SEL_HOLD_CYC
) (
    input  wire logic ref_clk_in,
    input  wire logic arst_n_in,
    gmbsc_if.host     link,
    input  wire logic start_in,
    input  wire logic boot_m_in,
    input  wire logic boot_s_in,
    input  wire logic power_off_in,
    input  wire logic tx_bit_in,
    output logic      busy_out,
    output logic      done_out,
    output logic      rx_bit_out,
    output logic      pps_out
);
    localparam int CW = $clog2(RST_HOLD_CYC + SEL_HOLD_CYC + 1);

    gmbsc_pkg::gmbsc_host_t st_q;
    gmbsc_pkg::gmbsc_host_t st_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic [1:0]    boot_q;
    logic [1:0]    boot_d;
    logic          roe_q;
    logic          roe_d;
    logic [1:0]    soe_q;
    logic [1:0]    soe_d;

    // Start is ignored while a sequence runs
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        boot_d = boot_q;
        case (st_q)
            gmbsc_pkg::H_IDLE: begin
                if (start_in) begin
                    st_d   = gmbsc_pkg::H_RST;
                    boot_d = {boot_s_in, boot_m_in};
                    cnt_d  = CW'(RST_HOLD_CYC - 1);
                end
            end
            gmbsc_pkg::H_RST: begin
                if (cnt_q == '0) begin
                    st_d  = gmbsc_pkg::H_HOLD;
                    cnt_d = CW'(SEL_HOLD_CYC - 1);
                end else begin
                    cnt_d = cnt_q - 1'b1; // [RQ5]
                end
            end
            gmbsc_pkg::H_HOLD: begin
                // Selects outlast the release so the module sees them
                if (cnt_q == '0) begin
                    st_d = gmbsc_pkg::H_DONE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            gmbsc_pkg::H_DONE: begin
                st_d = gmbsc_pkg::H_IDLE;
            end
            default: begin
                st_d = gmbsc_pkg::H_IDLE;
            end
        endcase
        roe_d = (st_d == gmbsc_pkg::H_RST); // [RQ5] [RQ7]
        soe_d = ((st_d == gmbsc_pkg::H_RST) || (st_d == gmbsc_pkg::H_HOLD)) ?
                boot_d : 2'b00;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q   <= gmbsc_pkg::H_IDLE;
            cnt_q  <= '0;
            boot_q <= 2'b00;
            roe_q  <= 1'b0;
            soe_q  <= 2'b00;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            boot_q <= boot_d;
            roe_q  <= roe_d;
            soe_q  <= soe_d;
        end
    end

    // Open-drain: only ever pull low, never drive high [RQ8]
    assign link.rst_out  = 1'b0;
    assign link.selm_out = gmbsc_pkg::SEL_BOOT;
    assign link.sels_out = gmbsc_pkg::SEL_BOOT;
    assign link.rst_oe   = roe_q;
    assign link.selm_oe  = soe_q[0];
    assign link.sels_oe  = soe_q[1];

    logic busy_q;
    logic done_q;
    logic txo_q;
    logic txe_q;
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            txo_q  <= 1'b1;
            txe_q  <= 1'b0;
            s1_q   <= 2'b01;
            s2_q   <= 2'b01;
        end else begin
            busy_q <= (st_d != gmbsc_pkg::H_IDLE);
            done_q <= (st_d == gmbsc_pkg::H_DONE);
            txo_q  <= tx_bit_in;
            txe_q  <= !power_off_in; // [RQ17]
            s1_q   <= {link.pps, link.dev_tx};
            s2_q   <= s1_q;
        end
    end
    assign busy_out        = busy_q;
    assign done_out        = done_q;
    assign link.host_tx    = txo_q;
    assign link.host_tx_oe = txe_q;
    assign rx_bit_out      = s2_q[0];
    assign pps_out         = s2_q[1];
endmodule
`default_nettype wire

// File: rtl/gmbsc_if.sv
// Pin-level link between host controller and positioning module.
// Open-drain pins resolve here; module has internal pull-ups.
`timescale 1ns/10ps
`default_nettype none
interface gmbsc_if;
    logic rst_out;
    logic rst_oe;
    logic selm_out;
    logic selm_oe;
    logic sels_out;
    logic sels_oe;
    logic host_tx;
    logic host_tx_oe;
    logic dev_tx;
    logic pps;
    logic rst_lvl;
    logic selm_lvl;
    logic sels_lvl;
    logic rx_lvl;

    // Undriven open-drain pins float high through internal pull-ups
    assign rst_lvl  = rst_oe ? rst_out : 1'b1;
    assign selm_lvl = selm_oe ? selm_out : 1'b1;
    assign sels_lvl = sels_oe ? sels_out : 1'b1;
    // Released serial line reads low when main power is off
    assign rx_lvl   = host_tx_oe ? host_tx : 1'b0;

    modport dev (
        input  rst_lvl,
        input  selm_lvl,
        input  sels_lvl,
        input  rx_lvl,
        output dev_tx,
        output pps
    );
    modport host (
        output rst_out,
        output rst_oe,
        output selm_out,
        output selm_oe,
        output sels_out,
        output sels_oe,
        output host_tx,
        output host_tx_oe,
        input  dev_tx,
        input  pps
    );
endinterface
`default_nettype wire

// File: rtl/gmbsc_pkg.sv
// Constants and types shared by both ends of the boot/mode control link.
// Assumes a single 125 MHz clock at each end.
// Overview of operation
// RQ1: One reset input resets both chips together
// RQ2: Shared reset active low, high lets chips run
// RQ3: Each chip select independently picks boot or user
// RQ4: Select sampled at reset release; asserted means boot
// RQ5: Host holds reset at least 100 ms
// RQ6: User-mode download ends in automatic self reset
// RQ7: Boot mode never self resets; host resets again
// RQ8: Host drives pins open-drain, no external pulls
// RQ9: Serial frame 1 start, 8 data, 1 stop
// RQ10: Serial rate 230400 bit/s after power-on
// RQ11: Fix, navigation, heading sentences on by default
// RQ12: One 100 ms pulse per second, rising aligned
// RQ13: Antennas classed ok/open/short, bias protected
// RQ14: Antenna report checksums 06, 50, 40
// RQ15: Backup only gives standby, later hot start
// RQ16: No backup, no aid data gives cold start
// RQ17: Host releases serial drive at power off
`default_nettype none
package gmbsc_pkg;
    localparam int CLK_HZ       = 125_000_000;
    localparam int CLK_KHZ      = CLK_HZ / 1000;
    localparam int RST_MIN_MS   = 100;
    localparam int RST_MIN_CYC  = RST_MIN_MS * CLK_KHZ;
    localparam int BAUD_BPS     = 230400;
    localparam int BAUD_CYC     = (CLK_HZ + BAUD_BPS / 2) / BAUD_BPS;
    localparam int FRAME_BITS   = 10;
    localparam int PPS_PERIOD_S = 1;
    localparam int PPS_HIGH_MS  = 100;
    localparam int PPS_PERIOD_CYC = PPS_PERIOD_S * CLK_HZ;
    localparam int PPS_HIGH_CYC   = PPS_HIGH_MS * CLK_KHZ;
    localparam int SEL_HOLD_CYC = 16;
    localparam logic       SEL_BOOT    = 1'b0;
    localparam logic [3:0] MSG_DEFAULT = 4'h7;
    localparam int MSG_FIX = 0;
    localparam int MSG_NAV = 1;
    localparam int MSG_HEADING = 2;
    localparam int MSG_BINARY  = 3;
    localparam logic [7:0] CKS_SHORT = 8'h06;
    localparam logic [7:0] CKS_OK    = 8'h50;
    localparam logic [7:0] CKS_OPEN  = 8'h40;

    typedef enum logic [1:0] {
        CH_RESET = 2'b00,
        CH_USER  = 2'b01,
        CH_BOOT  = 2'b10
    } gmbsc_chip_t;

    typedef enum logic [1:0] {
        ANT_OK    = 2'b00,
        ANT_OPEN  = 2'b01,
        ANT_SHORT = 2'b10
    } gmbsc_ant_t;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_RST  = 2'b01,
        H_HOLD = 2'b11,
        H_DONE = 2'b10
    } gmbsc_host_t;
endpackage
`default_nettype wire

// File: verification/gmbsc_monitor.sv
// Concurrent checks on the host/module pin link.
// Assumes link signals wired in plainly; one clock, async low reset.
`timescale 1ns/10ps
`default_nettype none
module gmbsc_monitor #(
    parameter int RST_HOLD_CYC = gmbsc_pkg::RST_MIN_CYC,
    parameter int SEL_HOLD_CYC = gmbsc_pkg::SEL_HOLD_CYC,
    parameter int PPS_HIGH_CYC = gmbsc_pkg::PPS_HIGH_CYC
) (
    input  wire logic ref_clk_in,
    input  wire logic arst_n_in,
    input  wire logic rst_out,
    input  wire logic rst_oe,
    input  wire logic selm_out,
    input  wire logic selm_oe,
    input  wire logic sels_out,
    input  wire logic sels_oe,
    input  wire logic rst_lvl,
    input  wire logic dev_tx,
    input  wire logic pps
);
    localparam int BAUD = gmbsc_pkg::BAUD_CYC;
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    logic [31:0] rst_run_q, rst_run_d, sel_run_q, sel_run_d;
    logic [31:0] hi_run_q, hi_run_d, lo_run_q, lo_run_d, pps_run_q, pps_run_d;

    always_comb begin
        rst_run_d = rst_oe ? rst_run_q + 32'h1 : 32'h0;
        sel_run_d = selm_oe ? sel_run_q + 32'h1 : 32'h0;
        hi_run_d  = dev_tx ? hi_run_q + 32'h1 : 32'h0;
        lo_run_d  = dev_tx ? 32'h0 : lo_run_q + 32'h1;
        pps_run_d = pps ? pps_run_q + 32'h1 : 32'h0;
    end
    // Idle line after reset counts as a long stop bit
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_run_q <= 32'h0;
            sel_run_q <= 32'h0;
            hi_run_q  <= 32'hffff;
            lo_run_q  <= 32'h0;
            pps_run_q <= 32'h0;
        end else begin
            rst_run_q <= rst_run_d;
            sel_run_q <= sel_run_d;
            hi_run_q  <= hi_run_d;
            lo_run_q  <= lo_run_d;
            pps_run_q <= pps_run_d;
        end
    end

    chk_rst_hold_len: assert property ($fell(rst_oe) |-> rst_run_q == RST_HOLD_CYC)
        else $error("reset drive length wrong");
    chk_sel_hold_len: assert property ($fell(selm_oe) |->
        sel_run_q == RST_HOLD_CYC + SEL_HOLD_CYC)
        else $error("select drive length wrong");
    chk_sel_outlasts_rst: assert property ($fell(rst_oe) && $past(selm_oe) |->
        selm_oe [*4])
        else $error("select released before reset release");
    chk_sel_with_rst: assert property ($rose(selm_oe) || $rose(sels_oe) |-> $rose(rst_oe))
        else $error("select driven outside reset");
    chk_open_drain: assert property (rst_oe || selm_oe || sels_oe |->
        !(rst_out || selm_out || sels_out))
        else $error("open-drain pin driven high");
    chk_stop_bit_len: assert property ($fell(dev_tx) |-> hi_run_q >= BAUD)
        else $error("stop bit too short");
    chk_bit_period: assert property ($rose(dev_tx) |->
        lo_run_q != 0 && lo_run_q % BAUD == 0)
        else $error("serial bit time wrong");
    chk_pps_high_max: assert property (pps |-> pps_run_q < PPS_HIGH_CYC)
        else $error("time pulse too long");
    chk_reset_kills_pps: assert property (!rst_lvl [*6] |=> !pps)
        else $error("time pulse during reset");
    chk_reset_idles_tx: assert property (!rst_lvl [*6] |-> dev_tx)
        else $error("serial line active during reset");
endmodule
`default_nettype wire

// File: verification/gmbsc_test.sv
// Self-checking bench: host and module ends joined over the pin link.
// Assumes shortened reset and pulse counts and the default select count, set below.
`timescale 1ns/10ps
`default_nettype none
module gmbsc_test;
    localparam int RH = 50;
    localparam int SH = 16;
    localparam int PP = 200;
    localparam int PH = 20;
    localparam int BC = gmbsc_pkg::BAUD_CYC;
    logic        ref_clk, arst_n, start, boot_m, boot_s, power_off, tx_bit, busy, done;
    logic        rx_bit, pps_h, main_pwr, backup, aid, tx_valid, tx_ready, cfg_we;
    logic        standby, start_cold;
    logic [1:0]  dl_done, ant_oc, ant_uc, ant_bias;
    logic [3:0]  cfg_msg, chip_state, msg_en, ant_state;
    logic [7:0]  tx_data;
    logic [15:0] ant_cksum;
    logic [31:0] rnd_q;
    int          fails, cmp_count, n, hi, lo;

    gmbsc_if i_gmbsc_if ();
    gmbsc_device #(.PPS_PERIOD_CYC(PP), .PPS_HIGH_CYC(PH)) i_gmbsc_device (
        .ref_clk_in(ref_clk), .arst_n_in(arst_n), .link(i_gmbsc_if), .main_pwr_in(main_pwr),
        .backup_supply_in(backup), .aid_data_in(aid), .dl_done_in(dl_done),
        .tx_data_in(tx_data), .tx_valid_in(tx_valid), .ant_overcur_in(ant_oc),
        .ant_undercur_in(ant_uc), .cfg_we_in(cfg_we), .cfg_msg_in(cfg_msg),
        .tx_ready_out(tx_ready), .chip_state_out(chip_state), .msg_en_out(msg_en),
        .ant_state_out(ant_state), .ant_bias_en_out(ant_bias), .ant_cksum_out(ant_cksum),
        .standby_out(standby), .start_cold_out(start_cold));
    gmbsc_host #(.RST_HOLD_CYC(RH), .SEL_HOLD_CYC(SH)) i_gmbsc_host (
        .ref_clk_in(ref_clk), .arst_n_in(arst_n), .link(i_gmbsc_if), .start_in(start),
        .boot_m_in(boot_m), .boot_s_in(boot_s), .power_off_in(power_off), .tx_bit_in(tx_bit),
        .busy_out(busy), .done_out(done), .rx_bit_out(rx_bit), .pps_out(pps_h));
    gmbsc_monitor #(.RST_HOLD_CYC(RH), .SEL_HOLD_CYC(SH), .PPS_HIGH_CYC(PH)) i_gmbsc_monitor (
        .ref_clk_in(ref_clk), .arst_n_in(arst_n), .rst_out(i_gmbsc_if.rst_out),
        .rst_oe(i_gmbsc_if.rst_oe), .selm_out(i_gmbsc_if.selm_out),
        .selm_oe(i_gmbsc_if.selm_oe), .sels_out(i_gmbsc_if.sels_out),
        .sels_oe(i_gmbsc_if.sels_oe), .rst_lvl(i_gmbsc_if.rst_lvl),
        .dev_tx(i_gmbsc_if.dev_tx), .pps(i_gmbsc_if.pps));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    function automatic logic frame_bit(input logic [7:0] b, input int i);
        return (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
    endfunction
    // Short wins over open when both senses fire
    function automatic logic [1:0] ant_code(input logic oc, input logic uc);
        return oc ? 2'b10 : (uc ? 2'b01 : 2'b00);
    endfunction
    function automatic logic [7:0] ant_cks(input logic [1:0] c);
        return (c == 2'b10) ? 8'h06 : ((c == 2'b01) ? 8'h40 : 8'h50);
    endfunction
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("TB: %0d compares, %0d mismatches", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic limit(input int k);
        if (k >= 20000) begin
            fails++;
            $display("MISMATCH wait bound expected event seen timeout");
            tally_and_finish();
        end
    endtask
    task automatic run_seq(input logic bm, input logic bs);
        boot_m = bm;
        boot_s = bs;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        n = 1;
        while (done !== 1'b1) begin
            if (n == 10) check("chips held", {12'h0, chip_state}, 16'h0);
            if (n == 10) check("host busy", {15'h0, busy}, 16'h1);
            tick(1);
            n++;
            limit(n);
        end
        check("sequence length", n[15:0], 16'(RH + SH + 1));
        tick(4);
        check("host idle", {15'h0, busy}, 16'h0);
        check("chip mode", {12'h0, chip_state},
              {12'h0, bs ? 2'b10 : 2'b01, bm ? 2'b10 : 2'b01});
    endtask
    task automatic send_byte(input logic [7:0] b);
        tx_data = b;
        tx_valid = 1'b1;
        n = 0;
        while (tx_ready !== 1'b1) begin
            tick(1);
            n++;
            limit(n);
        end
        tick(1);
        tx_valid = 1'b0;
        tick(BC / 2);
        for (int i = 0; i < 10; i++) begin
            check("serial bit", {15'h0, i_gmbsc_if.dev_tx},
                  {15'h0, frame_bit(b, i)});
            check("host rx bit", {15'h0, rx_bit}, {15'h0, frame_bit(b, i)});
            tick(BC);
        end
    endtask
    task automatic wait_pps(input logic lvl, output int k);
        k = 0;
        while (i_gmbsc_if.pps !== lvl) begin
            tick(1);
            k++;
            limit(k);
        end
    endtask

    initial begin
        {arst_n, start, boot_m, boot_s, power_off, aid, tx_valid, cfg_we} = 8'h00;
        {tx_bit, main_pwr, backup} = 3'h7;
        {dl_done, ant_oc, ant_uc, cfg_msg, tx_data} = 18'h0;
        fails = 0;
        cmp_count = 0;
        rnd_q = 32'he4638c9c;
        tick(8);
        arst_n = 1'b1;
        check("default mask", {12'h0, msg_en}, 16'h7);
        tick(4);
        for (int i = 3; i >= 0; i--) run_seq(i[0], i[1]);
        run_seq(1'b1, 1'b0);
        dl_done = 2'b11;
        tick(1);
        dl_done = 2'b00;
        check("self reset", {12'h0, chip_state}, 16'h2);
        tick(1);
        check("after self reset", {12'h0, chip_state}, 16'h6);
        run_seq(1'b0, 1'b0);
        $display("TEST reset and mode done");
        rnd_q = xs(rnd_q);
        send_byte(8'h00);
        send_byte(8'hff);
        send_byte(rnd_q[7:0]);
        $display("TEST serial frame done");
        // A pulse already high would give a short first count
        wait_pps(1'b0, n);
        wait_pps(1'b1, n);
        wait_pps(1'b0, hi);
        wait_pps(1'b1, lo);
        check("pulse high", hi[15:0], 16'(PH));
        check("pulse period", 16'(hi + lo), 16'(PP));
        tick(2);
        check("host pulse", {15'h0, pps_h}, 16'h1);
        $display("TEST time pulse done");
        for (int i = 0; i < 8; i++) begin
            rnd_q = xs(rnd_q);
            ant_oc = (i < 3) ? {2{i == 2}} : rnd_q[1:0];
            ant_uc = (i < 3) ? {2{i > 0}} : rnd_q[3:2];
            tick(5);
            check("antenna state", {12'h0, ant_state}, {12'h0,
                  ant_code(ant_oc[1], ant_uc[1]), ant_code(ant_oc[0], ant_uc[0])});
            check("antenna bias", {14'h0, ant_bias}, {14'h0, ~ant_oc});
            check("antenna report", ant_cksum, {ant_cks(ant_code(ant_oc[1], ant_uc[1])),
                  ant_cks(ant_code(ant_oc[0], ant_uc[0]))});
        end
        $display("TEST antenna done");
        cfg_msg = rnd_q[7:4];
        cfg_we = 1'b1;
        tick(1);
        cfg_we = 1'b0;
        tick(1);
        check("mask write", {12'h0, msg_en}, {12'h0, cfg_msg});
        power_off = 1'b1;
        main_pwr = 1'b0;
        tick(6);
        check("standby", {15'h0, standby}, 16'h1);
        check("serial released", {15'h0, i_gmbsc_if.host_tx_oe}, 16'h0);
        main_pwr = 1'b1;
        power_off = 1'b0;
        tick(6);
        check("hot start", {14'h0, standby, start_cold}, 16'h0);
        check("mask restored", {12'h0, msg_en}, 16'h7);
        main_pwr = 1'b0;
        backup = 1'b0;
        tick(6);
        main_pwr = 1'b1;
        tick(6);
        check("cold start", {15'h0, start_cold}, 16'h1);
        $display("TEST power done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
